// ---- include/dpc_consts.vh ----
// Timing constants, grade codes and state encodings for the dual-port memory port controller.
`ifndef DPC_CONSTS_VH
`define DPC_CONSTS_VH
`define DPC_CLK_PERIOD_NS       8
`define DPC_ADDR_W              11
`define DPC_DATA_W              8
`define DPC_CNT_W               5
// Speed grade selection codes.
`define DPC_GRADE_20            2'h0
`define DPC_GRADE_25            2'h1
`define DPC_GRADE_35            2'h2
`define DPC_GRADE_55            2'h3
// Busy access delay from address, ns per grade.
`define DPC_BUSY_ACC_20         20
`define DPC_BUSY_ACC_25         20
`define DPC_BUSY_ACC_35         20
`define DPC_BUSY_ACC_55         30
// Minimum write pulse width, ns per grade.
`define DPC_WP_20               15
`define DPC_WP_25               15
`define DPC_WP_35               25
`define DPC_WP_55               30
// Write enable to output high-impedance, ns per grade.
`define DPC_WZ_20               10
`define DPC_WZ_25               10
`define DPC_WZ_35               15
`define DPC_WZ_55               30
// Data valid to end of write, ns per grade.
`define DPC_DW_20               10
`define DPC_DW_25               12
`define DPC_DW_35               15
`define DPC_DW_55               20
// Write hold after contention, ns per grade.
`define DPC_WH_20               12
`define DPC_WH_25               15
`define DPC_WH_35               20
`define DPC_WH_55               20
// Busy disable to valid data, ns per grade.
`define DPC_BDD_20              25
`define DPC_BDD_25              35
`define DPC_BDD_35              35
`define DPC_BDD_55              50
// Read access time from address, ns per grade.
`define DPC_AA_20               20
`define DPC_AA_25               25
`define DPC_AA_35               35
`define DPC_AA_55               55
// Arbitration priority set-up, ns.
`define DPC_APS_NS              5
// Slave busy set-up before write start, ns.
`define DPC_WB_NS               0
// States of the port sequencer.
`define DPC_ST_IDLE             3'h0
`define DPC_ST_SETUP            3'h1
`define DPC_ST_WPULSE           3'h2
`define DPC_ST_WHOLD            3'h3
`define DPC_ST_READ             3'h4
`define DPC_ST_REC              3'h5
`endif

// ---- core/dpc_sync2.v ----
// Two-stage synchroniser for one asynchronous pin level.
`timescale 1ns/100ps
`include "dpc_consts.vh"
module dpc_sync2 (
  input  wire clk_in,
  input  wire rst_b_in,
  input  wire async_in,
  output wire sync_out
);
  reg meta_q;
  reg sync_q;
  // Resets high because the busy pin idles high; data bits do not care.
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      meta_q <= 1'h1;
      sync_q <= 1'h1;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end
  assign sync_out = sync_q;
endmodule

// ---- core/dpc_port_ctrl.v ----
// Port master that drives one port of the asynchronous dual-port memory.
`timescale 1ns/100ps
`include "dpc_consts.vh"
module dpc_port_ctrl #(
  parameter [1:0] GRADE    = `DPC_GRADE_20,
  parameter       OE_LOW   = 1
) (
  input  wire                   clk_in,
  input  wire                   rst_b_in,
  input  wire                   req_valid_in,
  input  wire                   req_write_in,
  input  wire [`DPC_ADDR_W-1:0] req_addr_in,
  input  wire [`DPC_DATA_W-1:0] req_wdata_in,
  output wire                   req_ready_out,
  output reg                    rsp_valid_out,
  output reg  [`DPC_DATA_W-1:0] rsp_rdata_out,
  output reg  [`DPC_ADDR_W-1:0] mem_addr_out,
  output reg                    mem_sel_b_out,
  output reg                    mem_wr_b_out,
  output reg                    mem_gate_b_out,
  output reg  [`DPC_DATA_W-1:0] mem_data_out,
  output reg                    mem_data_oe_b_out,
  input  wire [`DPC_DATA_W-1:0] mem_data_in,
  input  wire                   mem_busy_b_in
);
  ////////////////////////////////////////////////////////////////////////////
  // Converts nanoseconds to whole cycles, rounding up, never below one.
  function [`DPC_CNT_W-1:0] ns2cyc;
    input integer ns;
    integer c;
    begin
      c = (ns + `DPC_CLK_PERIOD_NS - 1) / `DPC_CLK_PERIOD_NS;
      if (c < 1)
        c = 1;
      ns2cyc = c[`DPC_CNT_W-1:0];
    end
  endfunction
  function integer pick;
    input [1:0] g;
    input integer a;
    input integer b;
    input integer c;
    input integer d;
    begin
      case (g)
        `DPC_GRADE_20: pick = a;
        `DPC_GRADE_25: pick = b;
        `DPC_GRADE_35: pick = c;
        default:       pick = d;
      endcase
    end
  endfunction
  // Grade-dependent figures in ns, all chosen from one parameter.
  localparam integer BUSY_ACC_NS = pick(GRADE, `DPC_BUSY_ACC_20, `DPC_BUSY_ACC_25,
                                        `DPC_BUSY_ACC_35, `DPC_BUSY_ACC_55);
  localparam integer WP_NS  = pick(GRADE, `DPC_WP_20, `DPC_WP_25, `DPC_WP_35, `DPC_WP_55);
  localparam integer WZ_NS  = pick(GRADE, `DPC_WZ_20, `DPC_WZ_25, `DPC_WZ_35, `DPC_WZ_55);
  localparam integer DW_NS  = pick(GRADE, `DPC_DW_20, `DPC_DW_25, `DPC_DW_35, `DPC_DW_55);
  localparam integer WH_NS  = pick(GRADE, `DPC_WH_20, `DPC_WH_25, `DPC_WH_35, `DPC_WH_55);
  localparam integer BDD_NS = pick(GRADE, `DPC_BDD_20, `DPC_BDD_25, `DPC_BDD_35, `DPC_BDD_55);
  localparam integer AA_NS  = pick(GRADE, `DPC_AA_20, `DPC_AA_25, `DPC_AA_35, `DPC_AA_55);
  // Setup covers busy access and the priority lead; the two-cycle pin sync adds margin.
  localparam integer SETUP_NS = (BUSY_ACC_NS > `DPC_APS_NS) ? BUSY_ACC_NS : `DPC_APS_NS;
  localparam integer PULSE_NS = (OE_LOW != 0 && (WZ_NS + DW_NS) > WP_NS) ? (WZ_NS + DW_NS) : WP_NS;
  localparam [`DPC_CNT_W-1:0] SETUP_CYC = ns2cyc(SETUP_NS);
  localparam [`DPC_CNT_W-1:0] PULSE_CYC = ns2cyc(PULSE_NS);
  localparam [`DPC_CNT_W-1:0] HOLD_CYC  = ns2cyc(WH_NS);
  localparam [`DPC_CNT_W-1:0] READ_CYC  = ns2cyc((AA_NS > BDD_NS) ? AA_NS : BDD_NS);
  localparam [`DPC_CNT_W-1:0] REC_CYC   = ns2cyc(`DPC_CLK_PERIOD_NS);
  localparam [`DPC_CNT_W-1:0] CNT_ONE   = 5'h01;
  localparam [`DPC_CNT_W-1:0] CNT_ZERO  = 5'h00;

  ////////////////////////////////////////////////////////////////////////////
  wire busy_b_s;
  dpc_sync2 u_busy_sync (
    .clk_in   (clk_in),
    .rst_b_in (rst_b_in),
    .async_in (mem_busy_b_in),
    .sync_out (busy_b_s)
  );

  // Data bits are synchronised one by one.
  // This is safe only because the bus has settled well before the sample is used.
  // The two-cycle lag matches the busy path, so a reloaded read wait still lines up.
  wire [`DPC_DATA_W-1:0] rdata_s;
  genvar                 gi;
  generate
    for (gi = 0; gi < `DPC_DATA_W; gi = gi + 1) begin : g_data_sync
      dpc_sync2 u_data_sync (
        .clk_in   (clk_in),
        .rst_b_in (rst_b_in),
        .async_in (mem_data_in[gi]),
        .sync_out (rdata_s[gi])
      );
    end
  endgenerate

  reg [2:0]            st_q;
  reg [`DPC_CNT_W-1:0] cnt_q;
  reg                  wr_q;
  reg                  blocked_q;

  assign req_ready_out = (st_q == `DPC_ST_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st_q              <= `DPC_ST_IDLE;
      cnt_q             <= 5'h00;
      wr_q              <= 1'h0;
      blocked_q         <= 1'h0;
      rsp_valid_out     <= 1'h0;
      rsp_rdata_out     <= 8'h00;
      mem_addr_out      <= 11'h000;
      mem_sel_b_out     <= 1'h1;
      mem_wr_b_out      <= 1'h1;
      mem_gate_b_out    <= 1'h1;
      mem_data_out      <= 8'h00;
      mem_data_oe_b_out <= 1'h1;
    end else begin
      rsp_valid_out <= 1'h0;
      case (st_q)
        `DPC_ST_IDLE: begin
          if (req_valid_in) begin
            // Address moves only while both strobes are high.
            mem_addr_out  <= req_addr_in;
            mem_data_out  <= req_wdata_in;
            wr_q          <= req_write_in;
            blocked_q     <= 1'h0;
            mem_sel_b_out <= 1'h0;
            mem_gate_b_out <= (req_write_in && OE_LOW == 0) ? 1'h1 : 1'h0;
            cnt_q         <= SETUP_CYC;
            st_q          <= `DPC_ST_SETUP;
          end
        end
        `DPC_ST_SETUP: begin
          if (cnt_q > CNT_ONE) begin
            cnt_q <= cnt_q - CNT_ONE;
          end else if (wr_q) begin
            // Strobe falls only after busy has had time to settle.
            mem_wr_b_out      <= 1'h0;
            mem_data_oe_b_out <= 1'h0;
            cnt_q             <= PULSE_CYC;
            st_q              <= `DPC_ST_WPULSE;
          end else begin
            cnt_q <= READ_CYC;
            st_q  <= `DPC_ST_READ;
          end
        end
        `DPC_ST_WPULSE: begin
          if (!busy_b_s) begin
            // Lost arbitration: keep the write asserted until busy clears.
            blocked_q <= 1'h1;
            cnt_q     <= PULSE_CYC;
          end else if (blocked_q) begin
            cnt_q <= HOLD_CYC;
            st_q  <= `DPC_ST_WHOLD;
          end else if (cnt_q > CNT_ONE) begin
            cnt_q <= cnt_q - CNT_ONE;
          end else begin
            mem_wr_b_out <= 1'h1;
            cnt_q        <= REC_CYC;
            st_q         <= `DPC_ST_REC;
          end
        end
        `DPC_ST_WHOLD: begin
          if (!busy_b_s) begin
            cnt_q <= HOLD_CYC;
          end else if (cnt_q > CNT_ONE) begin
            cnt_q <= cnt_q - CNT_ONE;
          end else begin
            mem_wr_b_out <= 1'h1;
            cnt_q        <= REC_CYC;
            st_q         <= `DPC_ST_REC;
          end
        end
        `DPC_ST_READ: begin
          // Busy low means the other port is mid-write; restart the wait after release.
          if (!busy_b_s) begin
            cnt_q <= READ_CYC;
          end else if (cnt_q > CNT_ONE) begin
            cnt_q <= cnt_q - CNT_ONE;
          end else begin
            rsp_rdata_out <= rdata_s;
            rsp_valid_out <= 1'h1;
            cnt_q         <= REC_CYC;
            st_q          <= `DPC_ST_REC;
          end
        end
        `DPC_ST_REC: begin
          // Select rises after the write strobe, so the write ends on the strobe.
          mem_sel_b_out     <= 1'h1;
          mem_gate_b_out    <= 1'h1;
          mem_data_oe_b_out <= 1'h1;
          if (cnt_q > CNT_ONE) begin
            cnt_q <= cnt_q - CNT_ONE;
          end else begin
            cnt_q <= CNT_ZERO;
            st_q  <= `DPC_ST_IDLE;
          end
        end
        default: begin
          st_q <= `DPC_ST_IDLE;
        end
      endcase
    end
  end
endmodule

// ---- dv/dpc_port_monitor.sv ----
// Concurrent checks on the memory-side timing of the port controller.
`timescale 1ns/100ps
module dpc_port_monitor (
  input wire        clk_in,
  input wire        rst_b_in,
  input wire        req_valid_in,
  input wire        req_write_in,
  input wire        req_ready_out,
  input wire        rsp_valid_out,
  input wire [10:0] mem_addr_out,
  input wire        mem_sel_b_out,
  input wire        mem_wr_b_out,
  input wire [7:0]  mem_data_out,
  input wire        mem_data_oe_b_out,
  input wire        mem_busy_b_in
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  wire rd_take = req_valid_in && req_ready_out && !req_write_in;
  ////////////////////////////////////////////////////////////////////////////////
  chk_strobe_in_sel: assert property (!mem_wr_b_out |-> !mem_sel_b_out)
    else $error("write strobe low outside select");
  chk_addr_hold: assert property (!mem_wr_b_out |-> $stable(mem_addr_out) && $stable(mem_data_out))
    else $error("address or data moved during write");
  chk_drive_on_wr: assert property ($fell(mem_data_oe_b_out) |-> $fell(mem_wr_b_out))
    else $error("data driven before write strobe");
  chk_pulse_width: assert property ($fell(mem_wr_b_out) |-> !mem_wr_b_out [*3])
    else $error("write pulse too short");
  chk_setup_delay: assert property ($fell(mem_wr_b_out) |-> $past(!mem_sel_b_out, 3))
    else $error("write strobe before busy access delay");
  chk_hold_busy: assert property ($rose(mem_busy_b_in) && !mem_wr_b_out |-> !mem_wr_b_out [*3])
    else $error("write not held after busy release");
  chk_busy_blocks: assert property ($rose(mem_wr_b_out) |-> $past(mem_busy_b_in, 3))
    else $error("write ended while busy low");
  chk_read_wait: assert property (rd_take |-> !rsp_valid_out [*6] ##[1:3] rsp_valid_out)
    else $error("read answer out of window");
  cov_write: cover property ($fell(mem_wr_b_out));
  cov_hold: cover property ($rose(mem_busy_b_in) && !mem_wr_b_out);
  cov_read: cover property (rsp_valid_out);
endmodule
bind dpc_port_ctrl dpc_port_monitor u_mon (.clk_in(clk_in), .rst_b_in(rst_b_in), .req_valid_in(req_valid_in),
  .req_write_in(req_write_in), .req_ready_out(req_ready_out), .rsp_valid_out(rsp_valid_out),
  .mem_addr_out(mem_addr_out), .mem_sel_b_out(mem_sel_b_out), .mem_wr_b_out(mem_wr_b_out),
  .mem_data_out(mem_data_out), .mem_data_oe_b_out(mem_data_oe_b_out), .mem_busy_b_in(mem_busy_b_in));

// ---- dv/dpc_mem_model.sv ----
// Behavioural model of one memory port, with busy and a peek port for the far side.
`timescale 1ns/100ps
`include "dpc_consts.vh"
module dpc_mem_model (
  input  wire        sel_b_in,
  input  wire        wr_b_in,
  input  wire        gate_b_in,
  input  wire [10:0] addr_in,
  input  wire [7:0]  wdata_in,
  input  wire        oe_b_in,
  input  wire        contend_in,
  input  wire [10:0] peer_addr_in,
  output wire [7:0]  dq_out,
  output wire        busy_b_out,
  output wire [7:0]  peer_data_out
);
  reg  [7:0] mem_q [0:2047];
  reg  [7:0] last_q = 8'h00;
  wire [7:0] rd_dly;
  wire       rd_on = !sel_b_in && wr_b_in && !gate_b_in;
  ////////////////////////////////////////////////////////////////////////////////
  // All delays come from the fastest grade only, so slower grades go unexercised.
  assign #(`DPC_AA_20) rd_dly = mem_q[addr_in];
  // Busy follows select and match alike; no priority set-up is modelled.
  assign #(`DPC_BUSY_ACC_20) busy_b_out = !(contend_in && !sel_b_in && peer_addr_in == addr_in);
  assign #(`DPC_BDD_20) peer_data_out = mem_q[peer_addr_in];
  // A released bus shows the inverse of its last value, never a kind constant.
  assign dq_out = !oe_b_in ? wdata_in : rd_on ? rd_dly : ~last_q;
  always @* if (!oe_b_in) last_q = wdata_in; else if (rd_on) last_q = rd_dly;
  always @(posedge wr_b_in) if (!sel_b_in && busy_b_out) mem_q[addr_in] <= dq_out;
endmodule

// ---- dv/dpc_port_ctrl_tb.sv ----
// Self-checking bench of the port controller against the memory model.
`timescale 1ns/100ps
module dpc_port_ctrl_tb;
  reg         clk_in = 0;
  reg         rst_b_in = 0;
  reg         req_valid_in = 0;
  reg         req_write_in = 0;
  reg  [10:0] req_addr_in = 11'h000;
  reg  [7:0]  req_wdata_in = 8'h00;
  reg         contend = 0;
  reg  [10:0] peer_addr = 11'h000;
  wire        req_ready_out, rsp_valid_out, sel_b, wr_b, gate_b, oe_b, busy_b;
  wire [7:0]  rsp_rdata_out, wdata, dq, peer_data;
  wire [10:0] addr;
  integer     n_fail = 0;
  integer     compares = 0;
  integer     cycles = 0;
  initial forever #4 clk_in = ~clk_in;
  dpc_port_ctrl DUT (.clk_in(clk_in), .rst_b_in(rst_b_in), .req_valid_in(req_valid_in), .req_write_in(req_write_in),
    .req_addr_in(req_addr_in), .req_wdata_in(req_wdata_in), .req_ready_out(req_ready_out),
    .rsp_valid_out(rsp_valid_out), .rsp_rdata_out(rsp_rdata_out), .mem_addr_out(addr), .mem_sel_b_out(sel_b),
    .mem_wr_b_out(wr_b), .mem_gate_b_out(gate_b), .mem_data_out(wdata), .mem_data_oe_b_out(oe_b),
    .mem_data_in(dq), .mem_busy_b_in(busy_b));
  dpc_mem_model u_mem (.sel_b_in(sel_b), .wr_b_in(wr_b), .gate_b_in(gate_b), .addr_in(addr), .wdata_in(wdata),
    .oe_b_in(oe_b), .contend_in(contend), .peer_addr_in(peer_addr), .dq_out(dq), .busy_b_out(busy_b),
    .peer_data_out(peer_data));
  ////////////////////////////////////////////////////////////////////////////////
  task end_of_test;
    begin
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  always @(posedge clk_in) begin
    cycles = cycles + 1;
    if (cycles == 2000) begin
      n_fail = n_fail + 1;
      end_of_test;
    end
  end
  task chk(input [8*12-1:0] what, input [7:0] exp, input [7:0] got);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("FAIL %0s expected %h seen %h", what, exp, got);
      end
    end
  endtask
  // Requests are raised only when idle, so the next edge is sure to take them.
  task req(input w, input [10:0] a, input [7:0] d);
    begin
      while (req_ready_out !== 1'b1) @(posedge clk_in) #1;
      req_valid_in = 1;
      req_write_in = w;
      req_addr_in = a;
      req_wdata_in = d;
      @(posedge clk_in) #1;
      req_valid_in = 0;
    end
  endtask
  task rd(input [10:0] a, input [7:0] exp);
    integer i;
    begin
      req(0, a, 8'h00);
      for (i = 0; i < 20 && rsp_valid_out !== 1'b1; i = i + 1) @(posedge clk_in) #1;
      chk("read valid", 8'h01, {7'h00, rsp_valid_out});
      chk("read data", exp, rsp_rdata_out);
    end
  endtask
  task wait_wr;
    integer i;
    begin
      for (i = 0; i < 20 && wr_b !== 1'b0; i = i + 1) @(posedge clk_in) #1;
    end
  endtask
  task t_write_read;
    begin
      peer_addr = 11'h7FF;
      req(1, 11'h7FF, 8'hA5);
      wait_wr;
      #50;
      chk("peer data", 8'hA5, peer_data);
      @(posedge clk_in) #1;
      req(1, 11'h000, 8'h5A);
      rd(11'h7FF, 8'hA5);
      rd(11'h000, 8'h5A);
    end
  endtask
  task t_busy;
    begin
      req(1, 11'h123, 8'h11);
      while (req_ready_out !== 1'b1) @(posedge clk_in) #1;
      peer_addr = 11'h123;
      contend = 1;
      req(1, 11'h123, 8'h3C);
      wait_wr;
      repeat (10) @(posedge clk_in) #1;
      chk("strobe held", 8'h00, {7'h00, wr_b});
      chk("blocked", 8'h11, peer_data);
      contend = 0;
      rd(11'h123, 8'h3C);
      chk("peer data", 8'h3C, peer_data);
    end
  endtask
  initial begin
    repeat (5) @(posedge clk_in);
    #1;
    chk("idle pins", 8'h1F, {3'h0, req_ready_out, sel_b, wr_b, gate_b, oe_b});
    rst_b_in = 1;
    t_write_read;
    t_busy;
    end_of_test;
  end
endmodule
